// ===== dv/test_usb_port_switch_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_usb_port_switch_control;
  logic clk, rst_b, btn, ack, cv, rv, swap, boost;
  logic [3:0] cc, rs, u2, u3, vb, route;
  logic [1:0] ch, rc;
  logic [31:0] cd, rdat;
  logic [127:0] volt, curr;
  logic [4:0] ot, keep_alive_charge;
  int bad_count, compares, cyc;
  upsc_host_model i_host (.clk_i(clk), .rd_ack_i(ack), .rd_data_i(rdat),
    .cmd_valid_o(cv), .cmd_code_o(cc), .cmd_chan_o(ch), .cmd_data_o(cd),
    .rd_valid_o(rv), .rd_sel_o(rs), .rd_chan_o(rc));
  // unit id value is arbitrary
  upsc_top #(.UNIT_ID(32'h0bad_cafe)) i_dut (.clk_i(clk), .rst_b_i(rst_b),
    .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_chan_i(ch), .cmd_data_i(cd),
    .rd_valid_i(rv), .rd_sel_i(rs), .rd_chan_i(rc), .meas_volt_uv_i(volt),
    .meas_curr_ua_i(curr), .overtemp_i(ot), .hard_reset_btn_i(btn),
    .rd_ack_o(ack), .rd_data_o(rdat), .usb2_en_o(u2), .usb3_en_o(u3),
    .vbus_en_o(vb), .mux_route_o(route), .orientation_swap_o(swap),
    .hs_boost_o(boost), .keep_alive_charge_o(keep_alive_charge));
  always #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] s, input logic [1:0] c,
                      input logic [31:0] exp);
    logic [31:0] q;
    logic a;
    i_host.rd(s, c, q, a);
    chk({31'h0, a}, 32'h1);
    chk(q, exp);
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    clk = 0; rst_b = 0; btn = 0; ot = 5'h0;
    volt = {32'h004c_4b40, 32'h0049_3e00, 32'h0047_0001, 32'h004a_0002};
    curr = {32'h0000_0300, 32'h0000_0200, 32'h0000_0100, 32'h0000_0050};
    wcyc(4);
    rst_b = 1;
    wcyc(1);
    rchk(upsc_pkg::RD_MAP, 0, 32'h0055_00ff);
    i_host.cmd(upsc_pkg::CMD_USB2, 1, 0);
    rchk(upsc_pkg::RD_MAP, 0, 32'h0055_00fb);
    i_host.cmd(upsc_pkg::CMD_USB3, 3, 0);
    rchk(upsc_pkg::RD_MAP, 0, 32'h0015_00fb);
    i_host.cmd(upsc_pkg::CMD_VBUS, 0, 0);
    rchk(upsc_pkg::RD_MAP, 0, 32'h0015_00f9);
    i_host.cmd(upsc_pkg::CMD_ALL_LINES, 2, 0);
    rchk(upsc_pkg::RD_MAP, 0, 32'h0005_00c9);
    i_host.cmd(upsc_pkg::CMD_BOTH_DATA, 2, 1);
    rchk(upsc_pkg::RD_MAP, 0, 32'h0015_00d9);
    i_host.cmd(upsc_pkg::CMD_MAP_WRITE, 0, 32'hffff_ffff);
    i_host.cmd(upsc_pkg::CMD_USB2, 3, 0);
    rchk(upsc_pkg::RD_MAP, 0, 32'h0055_00bf);
    i_host.cmd(upsc_pkg::CMD_NOP, 1, 0);
    rchk(upsc_pkg::RD_MAP, 0, 32'h0055_00bf);
    rchk(4'hf, 0, 32'h0);
    for (int v = 1; v >= 0; v--) begin
      i_host.cmd(upsc_pkg::CMD_FLIP_SET, 0, v);
      rchk(upsc_pkg::RD_FLIP, 0, v);
      chk({31'h0, swap}, v);
    end
    rchk(upsc_pkg::RD_NET_ADDR, 0, 32'h6);
    rchk(upsc_pkg::RD_UNIT_ID, 0, 32'h0bad_cafe);
    for (int n = 0; n < 4; n++) begin
      rchk(upsc_pkg::RD_VOLT, n, volt[32*n+:32]);
      rchk(upsc_pkg::RD_CURR, n, curr[32*n+:32]);
      i_host.cmd(upsc_pkg::CMD_MUX_SELECT, 0, n);
      wcyc(1);
      chk({28'h0, route}, 32'h1 << n);
      rchk(upsc_pkg::RD_MUX, 0, n);
    end
    i_host.cmd(upsc_pkg::CMD_KAC_SET, 0, 32'h1f);
    wcyc(2);
    chk({27'h0, keep_alive_charge}, 32'h07);
    i_host.cmd(upsc_pkg::CMD_VBUS, 3, 0);
    wcyc(2);
    chk({27'h0, keep_alive_charge}, 32'h17);
    ot = 5'h02;
    wcyc(4);
    chk({27'h0, keep_alive_charge}, 32'h15);
    rchk(upsc_pkg::RD_KAC, 0, 32'h15);
    ot = 5'h0;
    i_host.cmd(upsc_pkg::CMD_BOOST_SET, 0, 1);
    rchk(upsc_pkg::RD_BOOST, 0, 32'h1);
    i_host.cmd(upsc_pkg::CMD_SYS_SET, 0, 32'h000a_b3c5);
    i_host.cmd(upsc_pkg::CMD_SAVE, 0, 0);
    chk({31'h0, boost}, 32'h0);
    rchk(upsc_pkg::RD_SAVED, 0, 32'h001a_b3c5);
    rst_b = 0;
    wcyc(2);
    rst_b = 1;
    wcyc(2);
    chk({31'h0, boost}, 32'h1);
    rchk(upsc_pkg::RD_ACTIVE, 0, 32'h1);
    btn = 1;
    wcyc(6);
    btn = 0;
    wcyc(8);
    chk({31'h0, boost}, 32'h0);
    rchk(upsc_pkg::RD_BOOST, 0, 32'h0);
    rchk(upsc_pkg::RD_SAVED, 0, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== dv/upsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the control port: command and read traffic only
module upsc_host_model (
  input wire logic clk_i,
  input wire logic rd_ack_i,
  input wire logic [31:0] rd_data_i,
  output logic cmd_valid_o,
  output logic [3:0] cmd_code_o,
  output logic [1:0] cmd_chan_o,
  output logic [31:0] cmd_data_o,
  output logic rd_valid_o,
  output logic [3:0] rd_sel_o,
  output logic [1:0] rd_chan_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 4'h0;
    cmd_chan_o = 2'h0;
    cmd_data_o = 32'h0;
    rd_valid_o = 1'b0;
    rd_sel_o = 4'h0;
    rd_chan_o = 2'h0;
  end
  task automatic cmd(input logic [3:0] c, input logic [1:0] ch,
                     input logic [31:0] d);
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_code_o = c;
    cmd_chan_o = ch;
    cmd_data_o = d;
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b0;
    // idle data never repeats the last value
    cmd_data_o = ~d;
  endtask
  task automatic rd(input logic [3:0] s, input logic [1:0] ch,
                    output logic [31:0] q, output logic ack);
    @(posedge clk_i);
    #1;
    rd_valid_o = 1'b1;
    rd_sel_o = s;
    rd_chan_o = ch;
    @(posedge clk_i);
    #1;
    rd_valid_o = 1'b0;
    q = rd_data_i;
    ack = rd_ack_i;
  endtask
endmodule
`default_nettype wire

// ===== dv/upsc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module upsc_top_assertions #(
  parameter int NCH = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic [1:0] cmd_chan_i,
  input wire logic [31:0] cmd_data_i,
  input wire logic rd_valid_i,
  input wire logic [3:0] rd_sel_i,
  input wire logic hard_reset_btn_i,
  input wire logic rd_ack_o,
  input wire logic [31:0] rd_data_o,
  input wire logic [NCH-1:0] usb2_en_o,
  input wire logic [NCH-1:0] usb3_en_o,
  input wire logic [NCH-1:0] vbus_en_o,
  input wire logic [NCH-1:0] mux_route_o,
  input wire logic orientation_swap_o,
  input wire logic hs_boost_o
);
  logic [1:0] up_ff;
  logic [7:0] btn_ff;
  logic [1:0] ch_q;
  logic d_q;
  logic quiet;
  logic take;
  // commands count only in run state and well clear of a button press
  assign quiet = btn_ff == 8'h0 && !hard_reset_btn_i;
  assign take = cmd_valid_i && up_ff != 2'h0 && quiet;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_ff <= 2'h0;
      btn_ff <= 8'h0;
      ch_q <= 2'h0;
      d_q <= 1'b0;
    end else begin
      up_ff <= (up_ff == 2'h2) ? up_ff : up_ff + 2'h1;
      btn_ff <= {btn_ff[6:0], hard_reset_btn_i};
      ch_q <= cmd_chan_i;
      d_q <= cmd_data_i[0];
    end
  end
  function automatic logic [31:0] map_of(logic [3:0] u2, u3, vb);
    map_of = {9'h0, u3[3], 1'b0, u3[2], 1'b0, u3[1], 1'b0, u3[0], 8'h0,
      vb[3], u2[3], vb[2], u2[2], vb[1], u2[1], vb[0], u2[0]};
  endfunction
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_usb2;
    take && cmd_code_i == upsc_pkg::CMD_USB2 |=> usb2_en_o[ch_q] == d_q
      && $stable(usb3_en_o) && $stable(vbus_en_o);
  endproperty
  a_usb2: assert property (p_usb2) else $error("usb2 cmd wrong");
  property p_usb3;
    take && cmd_code_i == upsc_pkg::CMD_USB3 |=> usb3_en_o[ch_q] == d_q
      && $stable(usb2_en_o) && $stable(vbus_en_o);
  endproperty
  a_usb3: assert property (p_usb3) else $error("usb3 cmd wrong");
  property p_all;
    take && cmd_code_i == upsc_pkg::CMD_ALL_LINES |=>
      {usb2_en_o[ch_q], usb3_en_o[ch_q], vbus_en_o[ch_q]} == {3{d_q}};
  endproperty
  a_all: assert property (p_all) else $error("port cmd wrong");
  property p_map;
    rd_valid_i && rd_sel_i == upsc_pkg::RD_MAP && up_ff == 2'h2 && quiet
      |=> rd_ack_o && rd_data_o == map_of($past(usb2_en_o),
      $past(usb3_en_o), $past(vbus_en_o));
  endproperty
  a_map: assert property (p_map) else $error("map read wrong");
  property p_flip;
    take && cmd_code_i == upsc_pkg::CMD_FLIP_SET |=> orientation_swap_o == d_q;
  endproperty
  a_flip: assert property (p_flip) else $error("flip wrong");
  property p_boost;
    up_ff == 2'h2 && quiet |-> $stable(hs_boost_o);
  endproperty
  a_boost: assert property (p_boost) else $error("boost moved");
  property p_onehot;
    $onehot0(mux_route_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two routes");
  property p_mux;
    take && cmd_code_i == upsc_pkg::CMD_MUX_SELECT |=> ##1
      mux_route_o == 4'h1 << $past(cmd_data_i[1:0], 2);
  endproperty
  a_mux: assert property (p_mux) else $error("route wrong");
  c_mux: cover property (take && cmd_code_i == upsc_pkg::CMD_MUX_SELECT);
  c_save: cover property (take && cmd_code_i == upsc_pkg::CMD_SAVE);
  c_map: cover property (rd_valid_i && rd_sel_i == upsc_pkg::RD_MAP);
endmodule
bind upsc_top upsc_top_assertions #(.NCH(NCH)) i_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i),
  .cmd_code_i(cmd_code_i), .cmd_chan_i(cmd_chan_i), .cmd_data_i(cmd_data_i),
  .rd_valid_i(rd_valid_i), .rd_sel_i(rd_sel_i),
  .hard_reset_btn_i(hard_reset_btn_i), .rd_ack_o(rd_ack_o),
  .rd_data_o(rd_data_o), .usb2_en_o(usb2_en_o), .usb3_en_o(usb3_en_o),
  .vbus_en_o(vbus_en_o), .mux_route_o(mux_route_o),
  .orientation_swap_o(orientation_swap_o), .hs_boost_o(hs_boost_o));
`default_nettype wire

// ===== hdl/upsc_line_map.sv
`timescale 1ns/1ps
`default_nettype none
// packs and unpacks per-channel enables into the hub line map word
module upsc_line_map #(
  parameter int NCH = upsc_pkg::NCH
) (
  input wire logic [NCH-1:0] usb2_i,
  input wire logic [NCH-1:0] usb3_i,
  input wire logic [NCH-1:0] vbus_i,
  input wire logic [31:0] word_i,
  output logic [31:0] word_o,
  output logic [NCH-1:0] usb2_o,
  output logic [NCH-1:0] usb3_o,
  output logic [NCH-1:0] vbus_o
);
  always_comb begin
    word_o = 32'h0000_0000;
    for (int n = 0; n < NCH; n++) begin
      word_o[upsc_pkg::MAP_USB2_BIT0 + upsc_pkg::MAP_STRIDE*n] =
        usb2_i[n];
      word_o[upsc_pkg::MAP_VBUS_BIT0 + upsc_pkg::MAP_STRIDE*n] =
        vbus_i[n];
      word_o[upsc_pkg::MAP_USB3_BIT0 + upsc_pkg::MAP_STRIDE*n] =
        usb3_i[n];
    end
  end

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      usb2_o[n] = word_i[upsc_pkg::MAP_USB2_BIT0 + upsc_pkg::MAP_STRIDE*n];
      vbus_o[n] = word_i[upsc_pkg::MAP_VBUS_BIT0 + upsc_pkg::MAP_STRIDE*n];
      usb3_o[n] = word_i[upsc_pkg::MAP_USB3_BIT0 + upsc_pkg::MAP_STRIDE*n];
    end
  end
endmodule
`default_nettype wire

// ===== hdl/upsc_pkg.sv
// Functional notes
// - keep-alive on inactive port feeds control 5V
// - keep-alive is plain supply, no negotiation
// - overtemperature switches off that keep-alive output
// - factory unique serial number readable by host
// - network base address reads 6 by default
// - save copies offset, slot, router, boost
// - settings apply only after save then reset
// - hard reset button restores factory defaults
// - port command sets all three enables
// - data command sets both data enables
// - hi-speed command changes only usb2 enable
// - superspeed command changes only usb3 enable
// - power command changes only vbus enable
// - per-channel vbus voltage and current readback
// - flip setting readable, writable, 1 swaps
// - boost affects only hi-speed drive strength
// - hard reset restores boost to zero
// - control port carries control traffic only
// - 32-bit line map, reserved bits zero
// - channel n usb2 bit 2n, vbus 2n+1
// - usb3 enables at bits 16,18,20,22
// - at most one mux channel routed
// - mux select index 0 to 3 only
package upsc_pkg;
  localparam int NCH = 4;
  localparam int CMD_W = 4;
  // command codes on the control-port command strobe
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_ALL_LINES = 4'h1;
  localparam logic [3:0] CMD_BOTH_DATA = 4'h2;
  localparam logic [3:0] CMD_USB2 = 4'h3;
  localparam logic [3:0] CMD_USB3 = 4'h4;
  localparam logic [3:0] CMD_VBUS = 4'h5;
  localparam logic [3:0] CMD_MAP_WRITE = 4'h6;
  localparam logic [3:0] CMD_FLIP_SET = 4'h7;
  localparam logic [3:0] CMD_BOOST_SET = 4'h8;
  localparam logic [3:0] CMD_MUX_SELECT = 4'h9;
  localparam logic [3:0] CMD_KAC_SET = 4'ha;
  localparam logic [3:0] CMD_SYS_SET = 4'hb;
  localparam logic [3:0] CMD_SAVE = 4'hc;
  // read selectors
  localparam logic [3:0] RD_MAP = 4'h0;
  localparam logic [3:0] RD_FLIP = 4'h1;
  localparam logic [3:0] RD_BOOST = 4'h2;
  localparam logic [3:0] RD_MUX = 4'h3;
  localparam logic [3:0] RD_UNIT_ID = 4'h4;
  localparam logic [3:0] RD_NET_ADDR = 4'h5;
  localparam logic [3:0] RD_VOLT = 4'h6;
  localparam logic [3:0] RD_CURR = 4'h7;
  localparam logic [3:0] RD_KAC = 4'h8;
  localparam logic [3:0] RD_SAVED = 4'h9;
  localparam logic [3:0] RD_ACTIVE = 4'ha;
  // line map field positions
  localparam int MAP_USB2_BIT0 = 0;
  localparam int MAP_VBUS_BIT0 = 1;
  localparam int MAP_USB3_BIT0 = 16;
  localparam int MAP_STRIDE = 2;
  localparam logic [31:0] MAP_VALID = 32'h0055_00ff;
  localparam logic [31:0] MAP_RESET = 32'h0055_00ff;
  // saved system settings word: [7:0] offset, [11:8] slot,
  // [19:12] router, [20] boost
  localparam int SYS_OFS_LSB = 0;
  localparam int SYS_SLOT_LSB = 8;
  localparam int SYS_RTR_LSB = 12;
  localparam int SYS_BOOST_BIT = 20;
  localparam int SYS_W = 21;
  localparam logic [20:0] SYS_FACTORY = 21'h00_0000;
  localparam logic [7:0] NET_ADDR_DEFAULT = 8'h06;
  localparam logic [3:0] MUX_RESET = 4'h0;
  typedef enum logic [1:0] {UPSC_IDLE, UPSC_WIPE, UPSC_RUN} upsc_state_t;
endpackage

// ===== hdl/upsc_top.sv
`timescale 1ns/1ps
`default_nettype none
// control logic of the four-channel switch, driven by decoded commands
// from the full-speed control port
module upsc_top #(
  parameter int NCH = upsc_pkg::NCH,
  parameter logic [31:0] UNIT_ID = 32'h1234_5678, // arbitrary value
  parameter logic [20:0] NV_INIT = upsc_pkg::SYS_FACTORY
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic [1:0] cmd_chan_i,
  input wire logic [31:0] cmd_data_i,
  input wire logic rd_valid_i,
  input wire logic [3:0] rd_sel_i,
  input wire logic [1:0] rd_chan_i,
  input wire logic [NCH*32-1:0] meas_volt_uv_i,
  input wire logic [NCH*32-1:0] meas_curr_ua_i,
  input wire logic [NCH:0] overtemp_i,
  input wire logic hard_reset_btn_i,
  output logic rd_ack_o,
  output logic [31:0] rd_data_o,
  output logic [NCH-1:0] usb2_en_o,
  output logic [NCH-1:0] usb3_en_o,
  output logic [NCH-1:0] vbus_en_o,
  output logic [NCH-1:0] mux_route_o,
  output logic orientation_swap_o,
  output logic hs_boost_o,
  output logic [NCH:0] keep_alive_charge_o
);
  // pin inputs pass two flip-flops
  logic [NCH:0] ot_s1_ff, ot_s2_ff;
  logic btn_s1_ff, btn_s2_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ot_s1_ff <= '0;
      ot_s2_ff <= '0;
      btn_s1_ff <= 1'b0;
      btn_s2_ff <= 1'b0;
    end else begin
      ot_s1_ff <= overtemp_i;
      ot_s2_ff <= ot_s1_ff;
      btn_s1_ff <= hard_reset_btn_i;
      btn_s2_ff <= btn_s1_ff;
    end
  end

  // startup sequencer: loads saved settings after reset
  upsc_pkg::upsc_state_t state_ff, nxt_state;
  always_comb begin
    case (state_ff)
      upsc_pkg::UPSC_IDLE: nxt_state = upsc_pkg::UPSC_RUN;
      upsc_pkg::UPSC_WIPE: nxt_state = upsc_pkg::UPSC_RUN;
      upsc_pkg::UPSC_RUN: nxt_state = upsc_pkg::UPSC_RUN;
      default: nxt_state = upsc_pkg::UPSC_IDLE;
    endcase
    if (btn_s2_ff)
      nxt_state = upsc_pkg::UPSC_WIPE;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      state_ff <= upsc_pkg::UPSC_IDLE;
    else
      state_ff <= nxt_state;
  end

  logic cmd_go;
  assign cmd_go = cmd_valid_i && state_ff == upsc_pkg::UPSC_RUN;

  // enable state, one copy shared by commands and the map
  logic [NCH-1:0] usb2_ff, usb3_ff, vbus_ff;
  logic [NCH-1:0] nxt_usb2, nxt_usb3, nxt_vbus;
  logic [NCH-1:0] m_usb2, m_usb3, m_vbus;
  logic [31:0] map_word;
  logic on_bit;
  logic [NCH-1:0] ch_hot;

  upsc_line_map #(.NCH(NCH)) u_map (
    .usb2_i(usb2_ff),
    .usb3_i(usb3_ff),
    .vbus_i(vbus_ff),
    .word_i(cmd_data_i),
    .word_o(map_word),
    .usb2_o(m_usb2),
    .usb3_o(m_usb3),
    .vbus_o(m_vbus)
  );

  always_comb begin
    on_bit = cmd_data_i[0];
    ch_hot = '0;
    ch_hot[cmd_chan_i] = 1'b1;
    nxt_usb2 = usb2_ff;
    nxt_usb3 = usb3_ff;
    nxt_vbus = vbus_ff;
    if (cmd_go) begin
      case (cmd_code_i)
        upsc_pkg::CMD_ALL_LINES: begin
          nxt_usb2 = on_bit ? usb2_ff | ch_hot : usb2_ff & ~ch_hot;
          nxt_usb3 = on_bit ? usb3_ff | ch_hot : usb3_ff & ~ch_hot;
          nxt_vbus = on_bit ? vbus_ff | ch_hot : vbus_ff & ~ch_hot;
        end
        upsc_pkg::CMD_BOTH_DATA: begin
          nxt_usb2 = on_bit ? usb2_ff | ch_hot : usb2_ff & ~ch_hot;
          nxt_usb3 = on_bit ? usb3_ff | ch_hot : usb3_ff & ~ch_hot;
        end
        upsc_pkg::CMD_USB2:
          nxt_usb2 = on_bit ? usb2_ff | ch_hot : usb2_ff & ~ch_hot;
        upsc_pkg::CMD_USB3:
          nxt_usb3 = on_bit ? usb3_ff | ch_hot : usb3_ff & ~ch_hot;
        upsc_pkg::CMD_VBUS:
          nxt_vbus = on_bit ? vbus_ff | ch_hot : vbus_ff & ~ch_hot;
        upsc_pkg::CMD_MAP_WRITE: begin
          nxt_usb2 = m_usb2;
          nxt_usb3 = m_usb3;
          nxt_vbus = m_vbus;
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      usb2_ff <= '1;
      usb3_ff <= '1;
      vbus_ff <= '1;
    end else begin
      usb2_ff <= nxt_usb2;
      usb3_ff <= nxt_usb3;
      vbus_ff <= nxt_vbus;
    end
  end

  // live settings, saved settings, mux and keep-alive
  logic flip_ff, nxt_flip;
  logic boost_live_ff, nxt_boost_live;
  logic boost_act_ff, nxt_boost_act;
  logic [20:0] sys_live_ff, nxt_sys_live;
  // nonvolatile copy survives the system reset; preset only at power-up
  logic [20:0] nv_ff = NV_INIT;
  logic [20:0] nxt_nv;
  logic [1:0] mux_ff, nxt_mux;
  logic [NCH:0] kac_ff, nxt_kac;
  always_comb begin
    nxt_flip = flip_ff;
    nxt_boost_live = boost_live_ff;
    nxt_boost_act = boost_act_ff;
    nxt_sys_live = sys_live_ff;
    nxt_nv = nv_ff;
    nxt_mux = mux_ff;
    nxt_kac = kac_ff;
    case (state_ff)
      upsc_pkg::UPSC_IDLE: begin
        // saved settings take effect only at startup
        nxt_boost_act = nv_ff[upsc_pkg::SYS_BOOST_BIT];
        nxt_boost_live = nv_ff[upsc_pkg::SYS_BOOST_BIT];
        nxt_sys_live = nv_ff;
      end
      upsc_pkg::UPSC_WIPE: begin
        nxt_nv = upsc_pkg::SYS_FACTORY;
        nxt_boost_act = 1'b0;
        nxt_boost_live = 1'b0;
        nxt_sys_live = upsc_pkg::SYS_FACTORY;
      end
      default: begin
        if (cmd_go) begin
          case (cmd_code_i)
            upsc_pkg::CMD_FLIP_SET: nxt_flip = cmd_data_i[0];
            upsc_pkg::CMD_BOOST_SET:
              nxt_boost_live = cmd_data_i[0];
            upsc_pkg::CMD_MUX_SELECT:
              nxt_mux = cmd_data_i[1:0];
            upsc_pkg::CMD_KAC_SET: nxt_kac = cmd_data_i[NCH:0];
            upsc_pkg::CMD_SYS_SET:
              nxt_sys_live[19:0] = cmd_data_i[19:0];
            upsc_pkg::CMD_SAVE: begin
              nxt_nv = sys_live_ff;
              nxt_nv[upsc_pkg::SYS_BOOST_BIT] = boost_live_ff;
            end
            default: ;
          endcase
        end
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flip_ff <= 1'b0;
      boost_live_ff <= 1'b0;
      boost_act_ff <= 1'b0;
      sys_live_ff <= upsc_pkg::SYS_FACTORY;
      mux_ff <= upsc_pkg::MUX_RESET[1:0];
      kac_ff <= '0;
    end else begin
      flip_ff <= nxt_flip;
      boost_live_ff <= nxt_boost_live;
      boost_act_ff <= nxt_boost_act;
      sys_live_ff <= nxt_sys_live;
      mux_ff <= nxt_mux;
      kac_ff <= nxt_kac;
    end
  end
  always_ff @(posedge clk_i)
    nv_ff <= nxt_nv;

  // physical controls; kac index NCH is the common port
  logic [NCH-1:0] route_ff, nxt_route;
  logic [NCH:0] kac_out_ff, nxt_kac_out;
  always_comb begin
    nxt_route = '0;
    nxt_route[mux_ff] = 1'b1;
    for (int n = 0; n < NCH; n++)
      // supply path only, enabled on inactive ports
      nxt_kac_out[n] = kac_ff[n] && !nxt_route[n] && !ot_s2_ff[n];
    // common port is inactive only while its vbus path is cut
    nxt_kac_out[NCH] = kac_ff[NCH] && !vbus_ff[mux_ff] &&
                       !ot_s2_ff[NCH];
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      route_ff <= '0;
      kac_out_ff <= '0;
    end else begin
      route_ff <= nxt_route;
      kac_out_ff <= nxt_kac_out;
    end
  end

  // readback over the control port, one cycle after the request
  logic rd_ack_ff, nxt_rd_ack;
  logic [31:0] rd_data_ff, nxt_rd_data;
  always_comb begin
    nxt_rd_ack = rd_valid_i;
    nxt_rd_data = rd_data_ff;
    if (rd_valid_i) begin
      case (rd_sel_i)
        upsc_pkg::RD_MAP: nxt_rd_data = map_word;
        upsc_pkg::RD_FLIP: nxt_rd_data = {31'h0, flip_ff};
        upsc_pkg::RD_BOOST: nxt_rd_data = {31'h0, boost_live_ff};
        upsc_pkg::RD_MUX: nxt_rd_data = {30'h0, mux_ff};
        upsc_pkg::RD_UNIT_ID: nxt_rd_data = UNIT_ID;
        upsc_pkg::RD_NET_ADDR:
          nxt_rd_data = {24'h0, upsc_pkg::NET_ADDR_DEFAULT};
        upsc_pkg::RD_VOLT:
          nxt_rd_data = meas_volt_uv_i[rd_chan_i*32 +: 32];
        upsc_pkg::RD_CURR:
          nxt_rd_data = meas_curr_ua_i[rd_chan_i*32 +: 32];
        upsc_pkg::RD_KAC:
          nxt_rd_data = {{(31-NCH){1'b0}}, kac_out_ff};
        upsc_pkg::RD_SAVED: nxt_rd_data = {11'h0, nv_ff};
        upsc_pkg::RD_ACTIVE: nxt_rd_data = {31'h0, boost_act_ff};
        default: nxt_rd_data = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ack_ff <= 1'b0;
      rd_data_ff <= 32'h0000_0000;
    end else begin
      rd_ack_ff <= nxt_rd_ack;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_ack_o = rd_ack_ff;
  assign rd_data_o = rd_data_ff;
  assign usb2_en_o = usb2_ff;
  assign usb3_en_o = usb3_ff;
  assign vbus_en_o = vbus_ff;
  assign mux_route_o = route_ff;
  assign orientation_swap_o = flip_ff;
  assign hs_boost_o = boost_act_ff;
  assign keep_alive_charge_o = kac_out_ff;
endmodule
`default_nettype wire
